// ==== rtl/sar_adc_serial_readout.sv ====
// sample fifo and 3-wire conversion/readout logic of the converter
// What this block does
// - conv_frame_n falling starts conversion; low time frames one transfer.
// - while conv_frame_n is high, track input and float serial_result_out.
// - 14 result bits go out most significant first, least significant last.
// - each frame shifts out the sample converted in the last frame that reached its 16th falling edge.
// - each shift_clock fall advances conversion and shows the next bit.
// - shift_clock may run free or come in bursts; both work.
// - frame start shows the first leading zero; shift_clock falls the rest.
// - after the least significant bit, falling edges before the 16th drive zeros.
// - shift_clock low during acquisition gives one leading zero.
// - shift_clock high when conv_frame_n falls gives two leading zeros, held or running.
// - frame ended before the 16th falling edge loses that sample's result.
// - shift_clock is both conversion clock and readout clock.
// - light and deep power-down, entered and left by serial activity only.
// - two static-clock frame pulses give nap; four give sleep.
// - one shift_clock pulse wakes; after sleep wait reference recovery time.
// - serial_result_out floats after the 16th falling edge, frame still low.
`timescale 1ns/1ps
`include "adc_readout_map.svh"

// ==========================================================================
// sample fifo
module sample_fifo #(
	parameter int WIDTH = `ADC_RESULT_BITS,
	parameter int DEPTH = `ADC_FIFO_DEPTH
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_push_valid,
	input  wire logic [WIDTH-1:0] i_push_data,
	output logic                  o_push_ready,
	output logic                  o_pop_valid,
	input  wire logic             i_pop_ready,
	output logic      [WIDTH-1:0] o_pop_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	assign push       = i_push_valid && o_push_ready;
	assign pop        = i_pop_ready && o_pop_valid;
	assign o_pop_data = mem[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= i_push_data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			count_reg    <= '0;
			o_push_ready <= 1'b1;
			o_pop_valid  <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
			count_reg    <= count_next;
			o_push_ready <= (count_next != (AW+1)'(DEPTH));
			o_pop_valid  <= (count_next != '0);
		end
	end
endmodule : sample_fifo

// ==========================================================================
// converter serial interface
module sar_adc_serial_readout #(
	parameter int WAKE_SLEEP_CYC = `ADC_WAKE_SLEEP_CYC
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_conv_frame_n,
	input  wire logic        i_shift_clock,
	input  wire logic        i_sample_valid,
	input  wire logic [13:0] i_sample_code,
	output logic             o_sample_ready,
	output logic             o_serial_result_out,
	output logic             o_serial_result_oe,
	output logic             o_tracking,
	output logic             o_sample_lost,
	output logic [1:0]       o_power_state,
	output logic             o_ref_ready
);
	localparam logic [4:0] LAST_EDGE = 5'(`ADC_FRAME_EDGES - 1);
	localparam logic [16:0] WAKE_LOAD = 17'(WAKE_SLEEP_CYC);

	adc_readout_pkg::pins_type   pin_s1_reg;
	adc_readout_pkg::pins_type   pin_s2_reg;
	adc_readout_pkg::pins_type   pin_s3_reg;
	adc_readout_pkg::sample_type fifo_out;
	adc_readout_pkg::sample_type held_reg;
	adc_readout_pkg::power_type  power_reg;
	logic                        frame_fall;
	logic                        frame_rise;
	logic                        sck_fall;
	logic                        sck_edge;
	logic                        fifo_valid;
	logic                        frame_active_reg;
	logic [`ADC_COUNT_BITS-1:0]  fall_count_reg;
	logic                        lead_two_reg;
	logic [13:0]                 sar_reg;
	logic [13:0]                 result_reg;
	logic                        conv_done_reg;
	logic [2:0]                  static_pulses_reg;
	logic [2:0]                  static_pulses_next;
	logic [16:0]                 wake_count_reg;

	// bit shown at stream position pos: leading zeros, data, trailing zeros
	function automatic logic stream_bit(input logic [13:0] res,
		input logic two, input logic [4:0] pos);
		logic [4:0] lead;
		logic [4:0] idx;
		lead = two ? 5'h2 : 5'h1;
		idx  = 5'h0;
		if (pos < lead || pos >= lead + 5'he) begin
			return 1'b0;
		end
		idx = 5'hd - (pos - lead);
		return res[idx[3:0]];
	endfunction : stream_bit

	// ======================================================================
	// pin synchronisers and edge detection
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_s1_reg <= '{frame_n: 1'b1, shift_clk: 1'b0};
			pin_s2_reg <= '{frame_n: 1'b1, shift_clk: 1'b0};
			pin_s3_reg <= '{frame_n: 1'b1, shift_clk: 1'b0};
		end else begin
			pin_s1_reg <= '{frame_n: i_conv_frame_n, shift_clk: i_shift_clock};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	assign frame_fall = pin_s3_reg.frame_n && !pin_s2_reg.frame_n;
	assign frame_rise = !pin_s3_reg.frame_n && pin_s2_reg.frame_n;
	// both clock styles look the same here: only edges are used
	assign sck_fall   = pin_s3_reg.shift_clk && !pin_s2_reg.shift_clk;
	assign sck_edge   = pin_s3_reg.shift_clk != pin_s2_reg.shift_clk;

	// ======================================================================
	// sample path: the acquired value is taken when the frame starts
	sample_fifo #(
		.WIDTH (`ADC_RESULT_BITS),
		.DEPTH (`ADC_FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk    (i_sys_clk),
		.i_reset_n    (i_reset_n),
		.i_push_valid (i_sample_valid),
		.i_push_data  (i_sample_code),
		.o_push_ready (o_sample_ready),
		.o_pop_valid  (fifo_valid),
		.i_pop_ready  (frame_fall),
		.o_pop_data   (fifo_out)
	);

	// ======================================================================
	// frame tracking and edge count
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frame_active_reg <= 1'b0;
			fall_count_reg   <= '0;
			lead_two_reg     <= 1'b1;
			o_tracking       <= 1'b1;
		end else if (frame_fall) begin
			frame_active_reg <= 1'b1;
			o_tracking       <= 1'b0;
			fall_count_reg   <= '0;
			lead_two_reg     <= pin_s2_reg.shift_clk;
		end else if (frame_rise) begin
			frame_active_reg <= 1'b0;
			o_tracking       <= 1'b1;
		end else if (sck_fall && frame_active_reg && fall_count_reg != 5'h1f) begin
			fall_count_reg <= fall_count_reg + 5'h1;
		end
	end

	// ======================================================================
	// successive approximation, one step per falling shift clock
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			held_reg      <= '0;
			sar_reg       <= '0;
			conv_done_reg <= 1'b0;
		end else if (frame_fall) begin
			if (fifo_valid) begin
				held_reg <= fifo_out;
			end
			sar_reg       <= '0;
			conv_done_reg <= 1'b0;
		end else if (sck_fall && frame_active_reg) begin
			if (fall_count_reg < 5'he) begin
				sar_reg[4'hd - fall_count_reg[3:0]] <=
					held_reg.code[4'hd - fall_count_reg[3:0]];
			end
			if (fall_count_reg == LAST_EDGE) begin
				conv_done_reg <= 1'b1;
			end
		end
	end

	// an early frame end keeps the old result and flags the loss
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			result_reg    <= '0;
			o_sample_lost <= 1'b0;
		end else begin
			o_sample_lost <= frame_rise && !conv_done_reg;
			if (frame_rise && conv_done_reg) begin
				result_reg <= sar_reg;
			end
		end
	end

	// ======================================================================
	// serial output
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_serial_result_out <= 1'b0;
			o_serial_result_oe  <= 1'b0;
		end else if (frame_fall) begin
			o_serial_result_out <= 1'b0;
			o_serial_result_oe  <= 1'b1;
		end else if (frame_rise) begin
			o_serial_result_oe  <= 1'b0;
		end else if (sck_fall && frame_active_reg) begin
			o_serial_result_out <= stream_bit(result_reg, lead_two_reg,
				fall_count_reg + 5'h1);
			if (fall_count_reg == LAST_EDGE) begin
				o_serial_result_oe <= 1'b0;
			end
		end
	end

	// ======================================================================
	// power-down by frame pulses with a static shift clock
	always_comb begin
		static_pulses_next = static_pulses_reg;
		if (sck_edge) begin
			static_pulses_next = 3'h0;
		end else if (frame_rise && static_pulses_reg != 3'h7) begin
			static_pulses_next = static_pulses_reg + 3'h1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			static_pulses_reg <= '0;
			power_reg         <= adc_readout_pkg::power_active;
			wake_count_reg    <= '0;
		end else begin
			static_pulses_reg <= static_pulses_next;
			if (wake_count_reg != '0) begin
				wake_count_reg <= wake_count_reg - 17'h1;
			end
			if (sck_edge && power_reg != adc_readout_pkg::power_active) begin
				power_reg <= adc_readout_pkg::power_active;
				if (power_reg == adc_readout_pkg::power_sleep) begin
					wake_count_reg <= WAKE_LOAD;
				end
			end else if (frame_rise && static_pulses_next == `ADC_SLEEP_PULSES) begin
				power_reg <= adc_readout_pkg::power_sleep;
			end else if (frame_rise && static_pulses_next == `ADC_NAP_PULSES) begin
				power_reg <= adc_readout_pkg::power_nap;
			end
		end
	end

	// the reference is only good again once the sleep recovery has run out
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_power_state <= 2'h0;
			o_ref_ready   <= 1'b1;
		end else begin
			o_power_state <= power_reg;
			o_ref_ready   <= power_reg != adc_readout_pkg::power_sleep
				&& wake_count_reg == '0;
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_frame_start;
		frame_fall;
	endsequence

	sequence s_last_edge;
		sck_fall && frame_active_reg && fall_count_reg == LAST_EDGE;
	endsequence

	property p_frame_start;
		s_frame_start |=> frame_active_reg && fall_count_reg == 5'h0
			&& o_serial_result_oe && !o_tracking;
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("frame start not taken");

	property p_float_idle;
		frame_rise |=> !o_serial_result_oe [*2];
	endproperty
	a_float_idle: assert property (p_float_idle)
		else $error("output driven outside frame");

	property p_first_zero;
		s_frame_start |=> o_serial_result_out == 1'b0;
	endproperty
	a_first_zero: assert property (p_first_zero)
		else $error("first bit not zero");

	property p_float_after_last;
		s_last_edge |=> !o_serial_result_oe;
	endproperty
	a_float_after_last: assert property (p_float_after_last)
		else $error("output not released after last edge");

	property p_one_lead;
		(s_frame_start and !pin_s2_reg.shift_clk) |=> !lead_two_reg;
	endproperty
	a_one_lead: assert property (p_one_lead)
		else $error("wrong leading zero count, clock low");

	property p_two_lead;
		(s_frame_start and pin_s2_reg.shift_clk) |=> lead_two_reg;
	endproperty
	a_two_lead: assert property (p_two_lead)
		else $error("wrong leading zero count, clock high");

	property p_trailing_zero;
		sck_fall && frame_active_reg && fall_count_reg >= 5'hf
			&& fall_count_reg != 5'h1f |=> !o_serial_result_out;
	endproperty
	a_trailing_zero: assert property (p_trailing_zero)
		else $error("trailing bit not zero");

	property p_msb_out;
		sck_fall && frame_active_reg && fall_count_reg == 5'h1
			&& lead_two_reg |=> o_serial_result_out == result_reg[13];
	endproperty
	a_msb_out: assert property (p_msb_out)
		else $error("msb not first after leading zeros");

	property p_latency;
		frame_rise && conv_done_reg |=> result_reg == $past(sar_reg);
	endproperty
	a_latency: assert property (p_latency)
		else $error("result not kept for next frame");

	property p_lost;
		frame_rise && !conv_done_reg |=> $stable(result_reg) && o_sample_lost;
	endproperty
	a_lost: assert property (p_lost)
		else $error("early frame end did not drop sample");

	property p_nap;
		frame_rise && !sck_edge && static_pulses_reg == 3'h1
			|=> power_reg == adc_readout_pkg::power_nap;
	endproperty
	a_nap: assert property (p_nap)
		else $error("nap not entered");

	property p_wake;
		sck_edge && power_reg != adc_readout_pkg::power_active
			|=> power_reg == adc_readout_pkg::power_active ##1 o_power_state == 2'h0;
	endproperty
	a_wake: assert property (p_wake)
		else $error("clock pulse did not wake");

endmodule : sar_adc_serial_readout

// ==== rtl/adc_readout_map.svh ====
// constants of the serial conversion and readout block
`ifndef ADC_READOUT_MAP_SVH
`define ADC_READOUT_MAP_SVH

`define ADC_RESULT_BITS     14
`define ADC_FRAME_EDGES     16
`define ADC_COUNT_BITS      5
`define ADC_FIFO_DEPTH      8
`define ADC_NAP_PULSES      3'h2
`define ADC_SLEEP_PULSES    3'h4
`define ADC_SYS_CLK_MHZ     100
`define ADC_WAKE_SLEEP_NS   1100000
`define ADC_WAKE_SLEEP_CYC  ((`ADC_WAKE_SLEEP_NS * `ADC_SYS_CLK_MHZ) / 1000)
`define ADC_WAKE_BITS       17

`endif

// ==== rtl/adc_readout_pkg.sv ====
// types shared by the serial conversion and readout block
package adc_readout_pkg;

	typedef struct packed {
		logic frame_n;
		logic shift_clk;
	} pins_type;

	typedef struct packed {
		logic [13:0] code;
	} sample_type;

	typedef enum logic [1:0] {
		power_active,
		power_nap,
		power_sleep
	} power_type;

endpackage : adc_readout_pkg

// ==== tb/adc_host_model.sv ====
// host side model: drives frame select and shift clock, captures the stream
`timescale 1ns/1ps

// ==========================================================================
// host controller model
module adc_host_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_serial_result_out,
	input  wire logic        i_serial_result_oe,
	output logic             o_conv_frame_n,
	output logic             o_shift_clock,
	output logic             o_frame_done,
	output logic [63:0]      o_frame_word
);
	logic line_reg;

	initial begin
		o_conv_frame_n = 1'b1;
		o_shift_clock  = 1'b0;
		o_frame_done   = 1'b0;
		o_frame_word   = 64'h0;
		line_reg       = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : wait_cyc

	// a released line shows the inverse of its last level, never a hold
	task automatic grab(input int p);
		wait_cyc(6);
		line_reg = i_serial_result_oe ? i_serial_result_out : ~line_reg;
		o_frame_word[p]      = i_serial_result_oe & line_reg;
		o_frame_word[32 + p] = i_serial_result_oe;
		wait_cyc(2);
	endtask : grab

	// one frame with n falling shift edges at 160 ns per period
	task automatic frame(input logic lead_hi, input int n);
		o_frame_word = 64'h0;
		if (lead_hi !== o_shift_clock) begin
			o_shift_clock = lead_hi;
			wait_cyc(8);
		end
		o_conv_frame_n = 1'b0;
		grab(0);
		for (int k = 1; k <= n; k++) begin
			if (!o_shift_clock) begin
				o_shift_clock = 1'b1;
				wait_cyc(8);
			end
			o_shift_clock = 1'b0;
			grab(k);
		end
		wait_cyc(8);
		o_conv_frame_n = 1'b1;
		wait_cyc(16);
		o_frame_done = 1'b1;
		wait_cyc(1);
		o_frame_done = 1'b0;
	endtask : frame

	// free-running clock: frame falls on a rising edge, 16 periods framed,
	// 4 periods of acquisition, so the clock never stops inside a sample
	task automatic frame_free(input int n);
		o_frame_word = 64'h0;
		o_shift_clock  = 1'b1;
		o_conv_frame_n = 1'b0;
		grab(0);
		for (int k = 1; k <= n; k++) begin
			o_shift_clock = 1'b0;
			grab(k);
			o_shift_clock = 1'b1;
			if (k < n)
				wait_cyc(8);
		end
		o_conv_frame_n = 1'b1;
		wait_cyc(7);
		o_frame_done = 1'b1;
		wait_cyc(1);
		o_frame_done = 1'b0;
		repeat (3) begin
			o_shift_clock = 1'b0;
			wait_cyc(8);
			o_shift_clock = 1'b1;
			wait_cyc(8);
		end
		o_shift_clock = 1'b0;
		wait_cyc(8);
	endtask : frame_free

	task automatic pulse_shift();
		o_shift_clock = 1'b1;
		wait_cyc(8);
		o_shift_clock = 1'b0;
		wait_cyc(8);
	endtask : pulse_shift
endmodule : adc_host_model

// ==== tb/sar_adc_serial_readout_bench.sv ====
// self-checking bench of the converter readout block
`timescale 1ns/1ps

// ==========================================================================
// bench top
module sar_adc_serial_readout_bench;
	localparam int WAKE = 20;
	logic        sys_clk, reset_n, sample_valid, sample_ready;
	logic        result_out, result_oe, tracking, lost, ref_ready;
	logic        frame_n, shift_clk, done, ok, have;
	logic [1:0]  power;
	logic [13:0] sample_code, cur, committed;
	logic [63:0] word;
	logic [64:0] e;
	logic [64:0] exp_q[$];
	logic [13:0] fifo_q[$];
	int          fail_count, cmp_count, lost_seen, lost_exp;
	int          seed = 32'h93a3;

	sar_adc_serial_readout #(.WAKE_SLEEP_CYC(WAKE)) dut (
		.i_sys_clk(sys_clk), .i_reset_n(reset_n),
		.i_conv_frame_n(frame_n), .i_shift_clock(shift_clk),
		.i_sample_valid(sample_valid), .i_sample_code(sample_code),
		.o_sample_ready(sample_ready), .o_serial_result_out(result_out),
		.o_serial_result_oe(result_oe), .o_tracking(tracking),
		.o_sample_lost(lost), .o_power_state(power),
		.o_ref_ready(ref_ready)
	);

	adc_host_model host (
		.i_sys_clk(sys_clk), .i_serial_result_out(result_out),
		.i_serial_result_oe(result_oe), .o_conv_frame_n(frame_n),
		.o_shift_clock(shift_clk), .o_frame_done(done),
		.o_frame_word(word)
	);

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		cmp_count++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// upper half: drive enable per position, lower half: data per position
	function automatic logic [63:0] stream(input logic lead_hi,
			input logic [13:0] code, input int n);
		logic [63:0] w;
		int          lead;
		w = 64'h0;
		lead = lead_hi ? 2 : 1;
		for (int p = 0; p <= n; p++) begin
			if (p < 16)
				w[32 + p] = 1'b1;
			if (p >= lead && p < lead + 14)
				w[p] = code[13 - (p - lead)];
		end
		return w;
	endfunction : stream

	task automatic push(input logic [13:0] c, output logic taken);
		@(negedge sys_clk);
		taken = sample_ready;
		sample_valid = 1'b1;
		sample_code = c;
		if (taken)
			fifo_q.push_back(c);
	endtask : push

	// an empty fifo leaves the previous sample in place
	task automatic run(input logic lead_hi, input int n,
			input logic free = 1'b0);
		if (fifo_q.size() > 0)
			cur = fifo_q.pop_front();
		exp_q.push_back({!have, stream(lead_hi, committed, n)});
		if (free)
			host.frame_free(n);
		else
			host.frame(lead_hi, n);
		if (n >= 16) begin
			committed = cur;
			have = 1'b1;
		end else
			lost_exp++;
		check(result_oe, 0);
		check(tracking, 1);
	endtask : run

	always @(posedge sys_clk) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0)
				check(1, 0);
			else begin
				e = exp_q.pop_front();
				if (!e[64])
					check(word, e[63:0]);
			end
		end
		if (lost === 1'b1)
			lost_seen++;
	end

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		#200000;
		fail_count++;
		end_sim();
	end

	initial begin
		reset_n = 1'b0;
		sample_valid = 1'b0;
		sample_code = 14'h0;
		have = 1'b0;
		committed = 14'h0;
		cur = 14'h0;
		repeat (3) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		// fill while the host stalls, then one refused word
		for (int i = 0; i < 8; i++) begin
			push(14'($random(seed)), ok);
			check(ok, 1);
		end
		push(14'h3fff, ok);
		check(ok, 0);
		@(negedge sys_clk);
		sample_valid = 1'b0;
		run(1'b0, 16);
		run(1'b1, 16);
		run(1'b0, 16);
		run(1'b1, 8);
		run(1'b0, 16);
		run(1'b0, 0);
		run(1'b0, 0);
		check(power, 2'(adc_readout_pkg::power_nap));
		run(1'b0, 0);
		run(1'b0, 0);
		check(power, 2'(adc_readout_pkg::power_sleep));
		check(ref_ready, 0);
		host.pulse_shift();
		check(power, 2'(adc_readout_pkg::power_active));
		check(ref_ready, 0);
		repeat (WAKE) @(negedge sys_clk);
		check(ref_ready, 1);
		push(14'($random(seed)), ok);
		push(14'($random(seed)), ok);
		push(14'($random(seed)), ok);
		@(negedge sys_clk);
		sample_valid = 1'b0;
		run(1'b1, 16);
		// free-running clock: two leading zeros, same latency
		run(1'b1, 16, 1'b1);
		run(1'b1, 16, 1'b1);
		run(1'b0, 16);
		repeat (20) @(negedge sys_clk);
		check(lost_seen, lost_exp);
		end_sim();
	end
endmodule : sar_adc_serial_readout_bench
